// *** design/clock_source_ctrl.sv ***
// clock-source control: strap decode, pll enable, oscillator watchdog, switch-over
// assumes osc and pll clock levels are synchronous samples of the pins
`timescale 1ns/1ps
module clock_source_ctrl
    import clk_src_pkg::*;
(
    input wire logic clk_sys_in, // system clock, 20 MHz
    input wire logic rst_n_in, // async hardware reset, active low
    input wire logic [2:0] clock_mode_straps_in, // strap pins, caught after reset
    input wire logic ext_clock_input_pin_in, // sampled oscillator input level
    input wire logic pll_clk_in, // sampled free-running pll clock level
    input wire logic cfg_wr_in, // write strobe, system config
    input wire logic [SYSCFG_WIDTH-1:0] cfg_wdata_in, // write data, system config
    input wire logic irq_clr_in, // clears clock failure flag
    output logic [SYSCFG_WIDTH-1:0] system_config_reg_out, // config register value
    output logic [2:0] clock_mode_out, // latched strap code
    output logic [2:0] cpu_src_out, // one-hot cpu clock source
    output logic pll_enable_out, // pll powered
    output logic pll_resync_out, // pulse: pll resync point
    output logic prescale_en_out, // cpu clock via 2:1 prescaler
    output logic cpu_clk_out, // selected cpu clock level
    output logic clock_fail_irq_out // sticky clock failure request
);
    // ========================================
    // strap capture after reset release
    logic strap_taken_q;
    logic [2:0] mode_q;
    logic [SYSCFG_WIDTH-1:0] syscfg_q;
    clk_src_t src_q;
    clk_src_t src_d;
    logic irq_q;
    logic osc_prev_q;
    logic pll_prev_q;
    logic [2:0] edge_cnt_q;
    logic div_q;
    logic cpu_clk_q;
    clk_src_t clk_sel_q; // source feeding the level, moved only while low
    logic resync_q;

    // ========================================
    // decode
    logic direct_mode;
    logic prescale_mode;
    logic osc_watchdog_disable;
    logic wdog_run;
    logic osc_edge;
    logic pll_tick;
    logic wdog_ovf;
    logic [2:0] resync_div;
    logic resync_hit;
    logic src_level;

    assign direct_mode = (mode_q == STRAP_DIRECT);
    assign prescale_mode = (mode_q == STRAP_PRESCALE);
    assign osc_watchdog_disable = syscfg_q[WDOG_DIS_BIT];
    assign wdog_run = strap_taken_q && (direct_mode || prescale_mode)
                      && !osc_watchdog_disable && (src_q == SRC_OSC);
    assign osc_edge = ext_clock_input_pin_in ^ osc_prev_q;
    assign pll_tick = pll_clk_in && !pll_prev_q;

    // input edges per resync point (half-steps counted on edges)
    assign resync_div = (mode_q == STRAP_MUL4) ? 3'h4 :
                        (mode_q == STRAP_MUL3) ? 3'h3 :
                        (mode_q == STRAP_MUL2) ? 3'h2 :
                        (mode_q == STRAP_MUL5) ? 3'h5 :
                        (mode_q == STRAP_MUL1P5) ? 3'h3 :
                        (mode_q == STRAP_MUL2P5) ? 3'h5 : 3'h1;
    assign resync_hit = osc_edge && (edge_cnt_q == resync_div - 3'h1);

    assign src_d = (src_q == SRC_FREE_RUN) ? SRC_FREE_RUN :
                   wdog_ovf ? SRC_FREE_RUN :
                   (direct_mode || prescale_mode) ? SRC_OSC : SRC_PLL_MUL;

    // prescaler halves the oscillator by toggling on its rising edges
    // the level follows clk_sel_q, not src_q, so a switch never cuts a high phase short
    assign src_level = (clk_sel_q == SRC_FREE_RUN) ? pll_clk_in :
                       (clk_sel_q == SRC_PLL_MUL) ? pll_clk_in :
                       prescale_mode ? div_q : ext_clock_input_pin_in;

    osc_wdog_counter #(
        .OVF_CYCLES(WDOG_OVF_CYCLES)
    ) u_wdog (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .run_in(wdog_run),
        .pll_tick_in(pll_tick),
        .osc_edge_in(osc_edge),
        .overflow_out(wdog_ovf)
    );

    // straps are a level caught by a clock edge, never by the reset itself
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            strap_taken_q <= 1'b0;
            mode_q <= STRAP_RESET;
        end
        else if (!strap_taken_q)
        begin
            strap_taken_q <= 1'b1;
            mode_q <= clock_mode_straps_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            syscfg_q <= SYSCFG_RESET;
        else if (cfg_wr_in)
            syscfg_q <= cfg_wdata_in;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            irq_q <= 1'b0;
        else if (wdog_ovf)
            irq_q <= 1'b1;
        else if (irq_clr_in)
            irq_q <= 1'b0;
    end

    // source state and edge history
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            src_q <= SRC_OSC;
            osc_prev_q <= 1'b0;
            pll_prev_q <= 1'b0;
        end
        else
        begin
            src_q <= strap_taken_q ? src_d : SRC_OSC;
            osc_prev_q <= ext_clock_input_pin_in;
            pll_prev_q <= pll_clk_in;
        end
    end

    // resync edge counter and prescaler divider
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            edge_cnt_q <= 3'h0;
            resync_q <= 1'b0;
            div_q <= 1'b0;
        end
        else
        begin
            if (osc_edge)
                edge_cnt_q <= resync_hit ? 3'h0 : edge_cnt_q + 3'h1;
            resync_q <= resync_hit && (src_q == SRC_PLL_MUL);
            if (osc_edge && ext_clock_input_pin_in)
                div_q <= !div_q;
        end
    end

    // glitch-free switch, change source only while output is low
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cpu_clk_q <= 1'b0;
            clk_sel_q <= SRC_OSC;
        end
        else
        begin
            cpu_clk_q <= src_level;
            if (!cpu_clk_q)
                clk_sel_q <= src_q;
        end
    end

    // registered outputs
    // pll off when disabled and not needed
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            system_config_reg_out <= SYSCFG_RESET;
            clock_mode_out <= STRAP_RESET;
            cpu_src_out <= SRC_OSC;
            pll_enable_out <= 1'b0;
            prescale_en_out <= 1'b0;
            clock_fail_irq_out <= 1'b0;
        end
        else
        begin
            system_config_reg_out <= syscfg_q;
            clock_mode_out <= mode_q;
            cpu_src_out <= src_q;
            pll_enable_out <= (src_q != SRC_OSC) || wdog_run;
            prescale_en_out <= prescale_mode && (src_q == SRC_OSC);
            clock_fail_irq_out <= irq_q;
        end
    end

    assign cpu_clk_out = cpu_clk_q;
    assign pll_resync_out = resync_q;

    // ========================================
    // checks
    free_run_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        src_q == SRC_FREE_RUN |=> src_q == SRC_FREE_RUN)
        else $error("left free-running source");
    ovf_switch_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        wdog_ovf |=> src_q == SRC_FREE_RUN && irq_q ##1 clock_fail_irq_out)
        else $error("overflow did not switch source");
    pll_mode_wdog_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        strap_taken_q && !direct_mode && !prescale_mode |-> !wdog_run)
        else $error("watchdog ran in pll mode");
    wdog_disable_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        osc_watchdog_disable && src_q == SRC_OSC |=> !pll_enable_out)
        else $error("pll powered while disabled");
    irq_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        irq_q && !irq_clr_in |=> irq_q)
        else $error("failure flag dropped");
    pll_on_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        src_q == SRC_PLL_MUL |=> pll_enable_out)
        else $error("pll off in multiply mode");
    cfg_reset_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(strap_taken_q) |-> !osc_watchdog_disable || $past(cfg_wr_in))
        else $error("watchdog not enabled after reset");
    disable_bit_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        cfg_wr_in && cfg_wdata_in[WDOG_DIS_BIT] |=> !wdog_run)
        else $error("disable bit ignored");
    sel_switch_low_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        clk_sel_q != $past(clk_sel_q) |-> !$past(cpu_clk_q))
        else $error("source moved during high phase");

endmodule : clock_source_ctrl

// *** design/clk_src_pkg.sv ***
// constants for the clock-source selector with oscillator watchdog
// assumes one system clock; oscillator and pll clocks arrive as sampled levels
// Operation
// - watchdog runs only in direct or prescaler modes
// - watchdog enabled after any reset
// - disable bit four turns watchdog off
// - enabled watchdog counts free-running pll clocks
// - every oscillator transition clears the counter
// - counter overflows after sixteen pll clocks
// - overflow switches clock, sets failure flag
// - switch is permanent until hardware reset
// - disabled watchdog: oscillator clock, pll off
// - other straps enable pll with factor
// - pll resyncs every factor-th input transition; every 3rd for x1.5, every 5th for x2.5
// - strap codes decode to eight clock modes
package clk_src_pkg;

    // ========================================
    // strap encodings
    localparam logic [2:0] STRAP_MUL4 = 3'h7;
    localparam logic [2:0] STRAP_MUL3 = 3'h6;
    localparam logic [2:0] STRAP_MUL2 = 3'h5;
    localparam logic [2:0] STRAP_MUL5 = 3'h4;
    localparam logic [2:0] STRAP_DIRECT = 3'h3;
    localparam logic [2:0] STRAP_MUL1P5 = 3'h2;
    localparam logic [2:0] STRAP_PRESCALE = 3'h1;
    localparam logic [2:0] STRAP_MUL2P5 = 3'h0;
    localparam logic [2:0] STRAP_RESET = 3'h7;

    // ========================================
    // watchdog and config constants
    localparam int WDOG_OVF_CYCLES = 16;
    localparam int WDOG_DIS_BIT = 4;
    localparam int SYSCFG_WIDTH = 16;
    localparam logic [15:0] SYSCFG_RESET = 16'h0000;

    // ========================================
    // cpu clock source selection, one-hot
    typedef enum logic [2:0] {
        SRC_OSC = 3'b001,
        SRC_PLL_MUL = 3'b010,
        SRC_FREE_RUN = 3'b100
    } clk_src_t;

endpackage : clk_src_pkg

// *** design/osc_wdog_counter.sv ***
// oscillator watchdog counter: counts pll ticks, cleared by input edges
// assumes tick and edge pulses are one system clock wide
`timescale 1ns/1ps
module osc_wdog_counter
    import clk_src_pkg::*;
#(
    parameter int OVF_CYCLES = WDOG_OVF_CYCLES
)
(
    input wire logic clk_sys_in, // system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic run_in, // watchdog active
    input wire logic pll_tick_in, // one free-running pll cycle
    input wire logic osc_edge_in, // oscillator transition seen
    output logic overflow_out // count reached overflow
);
    localparam int CW = $clog2(OVF_CYCLES + 1);
    localparam logic [CW-1:0] OVF_LAST = CW'(OVF_CYCLES - 1);

    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic ovf_hit;

    // an edge wins over a tick in the same cycle: clock is alive
    // edge clears count
    assign ovf_hit = run_in && pll_tick_in && !osc_edge_in && (count_q == OVF_LAST);
    assign count_d = (!run_in || osc_edge_in) ? '0 :
                     pll_tick_in ? count_q + CW'(1) : count_q;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count_q <= '0;
            overflow_out <= 1'b0;
        end
        else
        begin
            count_q <= ovf_hit ? '0 : count_d;
            overflow_out <= ovf_hit;
        end
    end

    // sixteen undisturbed ticks end in an overflow pulse
    ovf_count_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ovf_hit |=> overflow_out && count_q == '0)
        else $error("overflow not reported");
    edge_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        osc_edge_in |=> count_q == '0 && !overflow_out)
        else $error("edge did not clear counter");

endmodule : osc_wdog_counter

// *** verif/osc_source_model.sv ***
// behavioural partner: oscillator pin level and free-running pll level
// assumes the bench system clock drives it and it shares the bench reset
`timescale 1ns/1ps
module osc_source_model
(
    input wire logic clk_sys_in, // system clock
    input wire logic rst_n_in, // reset, active low
    input wire logic run_in, // oscillator running
    output logic osc_out, // oscillator pin level
    output logic pll_out // free-running pll level
);
    // ========================================
    // level sources
    // a failed crystal holds its last level, so a stop is a real loss of clock
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            osc_out <= 1'b0;
            pll_out <= 1'b0;
        end
        else
        begin
            if (run_in)
                osc_out <= ~osc_out;
            // pll free-runs, one cycle every two clocks
            pll_out <= ~pll_out;
        end
    end
endmodule : osc_source_model

// *** verif/tb_osc_watchdog_pll_clock_select.sv ***
// self-checking bench for the clock-source control block
// assumes the partner model supplies oscillator and pll levels
`timescale 1ns/1ps
module tb_osc_watchdog_pll_clock_select;
    import clk_src_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [2:0] straps = 3'h3;
    logic run = 1'b0;
    logic cfg_wr = 1'b0;
    logic [15:0] cfg_wdata = 16'h0000;
    logic irq_clr = 1'b0;
    logic osc;
    logic pll;
    logic [15:0] cfg_q;
    logic [2:0] mode;
    logic [2:0] src;
    logic pll_en;
    logic resync;
    logic pre_en;
    logic irq;
    logic cpu_clk;
    logic [15:0] cfg_w;
    logic [2:0] mode_w;
    logic [2:0] src_w;
    logic pll_en_w;
    logic pre_en_w;
    logic irq_w;
    logic cpu_clk_w;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int rs_cnt = 0;
    int base;
    logic [2:0] codes [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
    int edges [6] = '{4, 3, 2, 5, 3, 5};

    // ========================================
    // clock, partner and design
    always #25 clk_sys_in = ~clk_sys_in;
    osc_source_model part (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .run_in(run),
        .osc_out(osc), .pll_out(pll));
    clock_source_ctrl uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .clock_mode_straps_in(straps), .ext_clock_input_pin_in(osc), .pll_clk_in(pll),
        .cfg_wr_in(cfg_wr), .cfg_wdata_in(cfg_wdata), .irq_clr_in(irq_clr),
        .system_config_reg_out(cfg_w), .clock_mode_out(mode_w), .cpu_src_out(src_w),
        .pll_enable_out(pll_en_w), .pll_resync_out(resync), .prescale_en_out(pre_en_w),
        .cpu_clk_out(cpu_clk_w), .clock_fail_irq_out(irq_w));

    // outputs are caught mid-cycle so checks never race the launching edge
    always @(negedge clk_sys_in)
    begin
        cfg_q = cfg_w;
        mode = mode_w;
        src = src_w;
        pll_en = pll_en_w;
        pre_en = pre_en_w;
        irq = irq_w;
        cpu_clk = cpu_clk_w;
    end

    // resync pulse tally and hang guard; a stuck run ends as a failure
    always @(negedge clk_sys_in)
    begin
        cyc++;
        if (resync === 1'b1)
            rs_cnt++;
        if (cyc == 20000)
        begin
            err_count++;
            conclude();
        end
    end

    // ========================================
    // shared tasks
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : wait_cyc

    task automatic do_reset(input logic [2:0] code, input logic osc_run);
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        straps <= code;
        run <= osc_run;
        wait_cyc(6);
        rst_n_in <= 1'b1;
        wait_cyc(4);
    endtask : do_reset

    task automatic conclude();
        if (err_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // ========================================
    // scenarios
    task automatic t_reset_values();
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        wait_cyc(2);
        chk("mode", 16'(STRAP_RESET), 16'(mode));
        chk("src", 16'(SRC_OSC), 16'(src));
        chk("irq", 16'h0000, 16'(irq));
        chk("cfg", SYSCFG_RESET, cfg_q);
    endtask : t_reset_values

    // clock loss in direct mode, then a returning clock must not switch back
    task automatic t_direct_loss();
        do_reset(STRAP_DIRECT, 1'b1);
        chk("mode", 16'(STRAP_DIRECT), 16'(mode));
        wait_cyc(50);
        chk("src", 16'(SRC_OSC), 16'(src));
        run <= 1'b0;
        wait_cyc(26);
        chk("src", 16'(SRC_OSC), 16'(src));
        wait_cyc(14);
        chk("src", 16'(SRC_FREE_RUN), 16'(src));
        chk("irq", 16'h0001, 16'(irq));
        run <= 1'b1;
        wait_cyc(40);
        chk("src", 16'(SRC_FREE_RUN), 16'(src));
        chk("irq", 16'h0001, 16'(irq));
        irq_clr <= 1'b1;
        wait_cyc(1);
        irq_clr <= 1'b0;
        wait_cyc(2);
        chk("irq", 16'h0000, 16'(irq));
    endtask : t_direct_loss

    task automatic t_prescale_loss();
        do_reset(STRAP_PRESCALE, 1'b0);
        chk("pre", 16'h0001, 16'(pre_en));
        wait_cyc(40);
        chk("src", 16'(SRC_FREE_RUN), 16'(src));
        chk("irq", 16'h0001, 16'(irq));
    endtask : t_prescale_loss

    // watchdog switched off before the clock stops
    task automatic t_disabled();
        do_reset(STRAP_DIRECT, 1'b1);
        cfg_wdata <= 16'h0010;
        cfg_wr <= 1'b1;
        wait_cyc(1);
        cfg_wr <= 1'b0;
        wait_cyc(3);
        chk("cfg", 16'h0010, cfg_q);
        run <= 1'b0;
        wait_cyc(60);
        chk("src", 16'(SRC_OSC), 16'(src));
        chk("pll_en", 16'h0000, 16'(pll_en));
        chk("cpu_clk", 16'(osc), 16'(cpu_clk));
        chk("irq", 16'h0000, 16'(irq));
    endtask : t_disabled

    // every multiply code: pll on, resync every factor-th edge (3rd for x1.5, 5th for x2.5), no watchdog
    task automatic t_pll_modes();
        for (int i = 0; i < 6; i++)
        begin
            do_reset(codes[i], 1'b0);
            chk("src", 16'(SRC_PLL_MUL), 16'(src));
            chk("pll_en", 16'h0001, 16'(pll_en));
            chk("pre", 16'h0000, 16'(pre_en));
            base = rs_cnt;
            run <= 1'b1;
            wait_cyc(60);
            run <= 1'b0;
            wait_cyc(4);
            chk("resync", 16'(60 / edges[i]), 16'(rs_cnt - base));
            wait_cyc(40);
            chk("src", 16'(SRC_PLL_MUL), 16'(src));
            chk("irq", 16'h0000, 16'(irq));
        end
    endtask : t_pll_modes

    // ========================================
    // main sequence
    initial
    begin
        t_reset_values();
        t_direct_loss();
        t_prescale_loss();
        t_disabled();
        t_pll_modes();
        conclude();
    end
endmodule : tb_osc_watchdog_pll_clock_select
